// File: eag_pkg.sv
/*
 * eag_pkg: constants, field positions, register offsets and carrier types
 * of the effective address generator.
 * Assumes: 32-bit AHB-Lite register access, one 100 MHz clock.
 */
package eag_pkg;

    // effective address mode subfield values and the stack pointer register number
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_IND  = 3'h2;
    localparam logic [2:0] MODE_POST = 3'h3;
    localparam logic [2:0] MODE_PRE  = 3'h4;
    localparam logic [2:0] MODE_DISP = 3'h5;
    localparam logic [2:0] MODE_IDX  = 3'h6;
    localparam logic [2:0] SP_NUM    = 3'h7;

    // operand size codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // operation word layout
    localparam int EA_SRC_LSB   = 0;
    localparam int EA_DST_REG   = 9;
    localparam int EA_DST_MODE  = 6;
    localparam int OP_SIZE_LSB  = 6;
    localparam logic [15:0] JUMP_MASK  = 16'hFF80;
    localparam logic [15:0] JUMP_MATCH = 16'h4E80;

    // index extension word layout
    localparam int IDX_DA_BIT   = 15;
    localparam int IDX_REG_LSB  = 12;
    localparam int IDX_LONG_BIT = 11;
    localparam int IDX_RSV_LSB  = 8;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_OPWORD  = 8'h04;
    localparam logic [7:0] ADDR_EXT0    = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_SRC_LOC = 8'h1C;
    localparam logic [7:0] ADDR_DST_LOC = 8'h20;
    localparam logic [2:0] PAGE_DREG    = 3'h2;
    localparam logic [2:0] PAGE_AREG    = 3'h3;
    localparam logic [7:0] ADDR_USP     = 8'h80;
    localparam logic [7:0] ADDR_SSP     = 8'h84;
    localparam int         EXT_WORDS    = 4;

    // control and status fields
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_SUPER_BIT  = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_LEN_LSB    = 4;
    localparam int STAT_SRCX_LSB   = 8;
    localparam int STAT_DSTX_LSB   = 10;
    localparam int STAT_IMM_LSB    = 12;
    localparam int STAT_SPROG_BIT  = 16;
    localparam int STAT_SMEM_BIT   = 17;
    localparam int STAT_DMEM_BIT   = 18;
    localparam int STAT_HASD_BIT   = 19;
    localparam int STAT_DPROG_BIT  = 20;
    localparam int STAT_RSV_BIT    = 21;
    localparam int STAT_UNSUP_BIT  = 22;
    localparam int STAT_SIZE_LSB   = 24;

    // reset values
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic        SUPER_RESET = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SRC  = 3'b010,
        ST_DST  = 3'b100
    } eag_state_e;

    typedef struct packed {
        logic [5:0] src_ea;
        logic [5:0] dst_ea;
        logic       has_dst;
        logic [1:0] imm_words;
        logic [1:0] size;
        logic       jump;
    } eag_dec_s;

    typedef struct packed {
        logic [31:0] value;
        logic        is_mem;
        logic        is_prog;
        logic        wr_areg;
        logic [31:0] areg_new;
        logic        rsv_bad;
        logic        unsup;
    } eag_loc_s;

endpackage

// File: eag_decoder.sv
/*
 * eag_decoder: decodes the effective address fields of an operation word,
 * works out the instruction length and extension word layout, resolves the
 * operand locations and updates address registers by operand size.
 * Assumes: an AHB-Lite master on clk; software loads the operation word and
 * following words, then writes the start bit; register file lives here.
 */
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// How it works
// - instructions of one to five words (this code: at most four); length and operation from operation word only
// - following words: immediate, then source extension, then destination extension
// - each reference tagged program or data; operand writes always data
// - effective address splits into 3-bit mode and 3-bit register number
// - register-direct modes take operand from one of 16 registers, no memory
// - mode 000 selects the data register named by the register field
// - mode 001 selects the address register named by the register field
// - mode 010 uses address register contents as address, register unchanged
// - indirect and displacement are data references, jumps make them program
// - mode 011 uses register then adds operand size 1, 2 or 4
// - post-increment of stack pointer with byte size adds two
// - mode 100 first subtracts operand size, uses and keeps the result
// - pre-decrement of stack pointer with byte size subtracts two
// - displacement mode adds sign-extended 16-bit extension word to register
// - index word bit 15 picks data (0) or address (1) index register
// - index word bits 14 to 12 give the index register number
// - index word bit 11: 0 sign-extended low word, 1 full long
// - stack pointer references go to the active user or supervisor pointer
// - indexed address is register plus sign-extended low byte plus index
// - mode 101 is displacement, 110 indexed, register field names base
module eag_decoder
    import eag_pkg::*;
(
    input  wire logic        clk,        // 100 MHz clock
    input  wire logic        sys_rst,    // synchronous reset, active high
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // byte address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write when high
    input  wire logic [2:0]  hsize,      // transfer size
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready
    output logic             hreadyout,  // slave ready
    output logic             hresp,      // response, always okay
    output logic [31:0]      hrdata,     // read data
    output logic             busy        // decode in progress
);

    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction

    function automatic logic [1:0] ext_words(input logic [5:0] ea);
        if (ea[5:3] == MODE_DISP || ea[5:3] == MODE_IDX) begin
            ext_words = 2'h1;
        end else begin
            ext_words = 2'h0;
        end
    endfunction

    function automatic logic [31:0] step_bytes(input logic [1:0] sz, input logic is_sp);
        case (sz)
            SZ_BYTE: step_bytes = is_sp ? 32'h0000_0002 : 32'h0000_0001;
            SZ_WORD: step_bytes = 32'h0000_0002;
            default: step_bytes = 32'h0000_0004;
        endcase
    endfunction

    // everything comes from the operation word alone
    function automatic eag_dec_s decode(input logic [15:0] op);
        eag_dec_s d;
        d = '0;
        d.src_ea = op[EA_SRC_LSB +: 6];
        d.jump   = (op & JUMP_MASK) == JUMP_MATCH;
        if (op[15:14] == 2'h0 && op[13:12] != 2'h0) begin
            // two-operand move: destination register then mode
            d.has_dst = 1'b1;
            d.dst_ea  = {op[EA_DST_MODE +: 3], op[EA_DST_REG +: 3]};
            case (op[13:12])
                2'h1:    d.size = SZ_BYTE;
                2'h3:    d.size = SZ_WORD;
                default: d.size = SZ_LONG;
            endcase
        end else begin
            d.size = (op[OP_SIZE_LSB +: 2] == 2'h3) ? SZ_WORD : op[OP_SIZE_LSB +: 2];
            if (op[15:12] == 4'h0 && !op[8]) begin
                // immediate group: one word, two for long
                d.imm_words = (d.size == SZ_LONG) ? 2'h2 : 2'h1;
            end
        end
        decode = d;
    endfunction

    eag_state_e  state_q;
    logic [31:0] d_q [0:7];
    logic [31:0] a_q [0:6];
    logic [31:0] usp_q;
    logic [31:0] ssp_q;
    logic        super_q;
    logic [15:0] opword_q;
    logic [15:0] ext_q [0:EXT_WORDS-1];
    logic [31:0] src_loc_q;
    logic [31:0] dst_loc_q;
    logic [31:0] status_q;
    logic [31:0] rdata_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] a_view [0:7];
    eag_dec_s    dec;
    eag_loc_s    loc;
    logic [5:0]  cur_ea;
    logic [1:0]  ext_idx;
    logic [15:0] xw;
    logic [31:0] idx_raw;
    logic [31:0] idx_val;
    logic [31:0] base;
    logic [2:0]  len;
    logic        acc;
    logic        wr_now;
    logic        start;
    logic [31:0] rd_d;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign busy      = state_q != ST_IDLE;
    assign dec       = decode(opword_q);

    assign acc    = hsel && htrans[1] && hready;
    assign wr_now = wr_pend_q && !busy;  // writes while busy are dropped
    assign start  = wr_now && wr_addr_q == ADDR_CTRL && hwdata[CTRL_START_BIT];

    // address register view with the active stack pointer in slot seven
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            a_view[i] = a_q[i];
        end
        a_view[7] = super_q ? ssp_q : usp_q;
    end

    assign len = 3'h1 + {1'b0, dec.imm_words} + {1'b0, ext_words(dec.src_ea)}
               + (dec.has_dst ? {1'b0, ext_words(dec.dst_ea)} : 3'h0);

    // resolve the location for the stage in progress
    always_comb begin
        loc     = '0;
        cur_ea  = (state_q == ST_DST) ? dec.dst_ea : dec.src_ea;
        // immediate words first, source extension, then destination extension
        ext_idx = dec.imm_words + ((state_q == ST_DST) ? ext_words(dec.src_ea) : 2'h0);
        xw      = ext_q[ext_idx];
        base    = a_view[cur_ea[2:0]];
        idx_raw = xw[IDX_DA_BIT] ? a_view[xw[IDX_REG_LSB +: 3]] : d_q[xw[IDX_REG_LSB +: 3]];
        idx_val = xw[IDX_LONG_BIT] ? idx_raw : sext16(idx_raw[15:0]);
        case (cur_ea[5:3])
            MODE_DREG: begin
                loc.value = d_q[cur_ea[2:0]];
            end
            MODE_AREG: begin
                loc.value = base;
            end
            MODE_IND: begin
                loc.value  = base;
                loc.is_mem = 1'b1;
            end
            MODE_POST: begin
                loc.value    = base;
                loc.is_mem   = 1'b1;
                loc.wr_areg  = 1'b1;
                loc.areg_new = base + step_bytes(dec.size, cur_ea[2:0] == SP_NUM);
            end
            MODE_PRE: begin
                loc.areg_new = base - step_bytes(dec.size, cur_ea[2:0] == SP_NUM);
                loc.value    = loc.areg_new;
                loc.is_mem   = 1'b1;
                loc.wr_areg  = 1'b1;
            end
            MODE_DISP: begin
                loc.value  = base + sext16(xw);
                loc.is_mem = 1'b1;
            end
            MODE_IDX: begin
                loc.value   = base + sext8(xw[7:0]) + idx_val;
                loc.is_mem  = 1'b1;
                loc.rsv_bad = xw[IDX_RSV_LSB +: 3] != 3'h0;
            end
            default: begin
                loc.unsup = 1'b1;
            end
        endcase
        // jumps turn indirect, displacement and index into program references
        loc.is_prog = (state_q == ST_SRC) && dec.jump
                    && (cur_ea[5:3] == MODE_IND || cur_ea[5:3] == MODE_DISP
                        || cur_ea[5:3] == MODE_IDX);
    end

    // sequencer: source stage, then destination stage if any
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_SRC;
                    end
                end
                ST_SRC: begin
                    state_q <= dec.has_dst ? ST_DST : ST_IDLE;
                end
                ST_DST: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // bus address phase capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                wr_addr_q <= {haddr[7:2], 2'b00};
            end
        end
    end

    // read mux, sampled in the address phase
    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr[7:5] == PAGE_DREG) begin
            rd_d = d_q[haddr[4:2]];
        end else if (haddr[7:5] == PAGE_AREG) begin
            rd_d = a_view[haddr[4:2]];
        end else begin
            case ({haddr[7:2], 2'b00})
                ADDR_CTRL:    rd_d = {30'h0, super_q, 1'b0};
                ADDR_OPWORD:  rd_d = {16'h0, opword_q};
                ADDR_STATUS:  rd_d = status_q | {31'h0, busy};
                ADDR_SRC_LOC: rd_d = src_loc_q;
                ADDR_DST_LOC: rd_d = dst_loc_q;
                ADDR_USP:     rd_d = usp_q;
                ADDR_SSP:     rd_d = ssp_q;
                default: begin
                    if ({haddr[7:2], 2'b00} >= ADDR_EXT0 && {haddr[7:2], 2'b00} < ADDR_STATUS) begin
                        rd_d = {16'h0, ext_q[2'(haddr[4:2] - 3'h2)]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= REG_RESET;
        end else if (acc && !hwrite) begin
            rdata_q <= rd_d;
        end
    end

    // software loaded words and mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            super_q  <= SUPER_RESET;
            opword_q <= 16'h0000;
            for (int i = 0; i < EXT_WORDS; i++) begin
                ext_q[i] <= 16'h0000;
            end
        end else if (wr_now) begin
            if (wr_addr_q == ADDR_CTRL) begin
                super_q <= hwdata[CTRL_SUPER_BIT];
            end
            if (wr_addr_q == ADDR_OPWORD) begin
                opword_q <= hwdata[15:0];
            end
            for (int i = 0; i < EXT_WORDS; i++) begin
                if (wr_addr_q == ADDR_EXT0 + 8'(4 * i)) begin
                    ext_q[i] <= hwdata[15:0];
                end
            end
        end
    end

    // data registers, software only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                d_q[i] <= REG_RESET;
            end
        end else if (wr_now && wr_addr_q[7:5] == PAGE_DREG) begin
            d_q[wr_addr_q[4:2]] <= hwdata;
        end
    end

    // address registers and both stack pointers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 7; i++) begin
                a_q[i] <= REG_RESET;
            end
            usp_q <= REG_RESET;
            ssp_q <= REG_RESET;
        end else if (busy && loc.wr_areg) begin
            if (cur_ea[2:0] == SP_NUM) begin
                if (super_q) begin
                    ssp_q <= loc.areg_new;
                end else begin
                    usp_q <= loc.areg_new;
                end
            end else begin
                a_q[cur_ea[2:0]] <= loc.areg_new;
            end
        end else if (wr_now) begin
            if (wr_addr_q[7:5] == PAGE_AREG) begin
                if (wr_addr_q[4:2] == SP_NUM) begin
                    if (super_q) begin
                        ssp_q <= hwdata;
                    end else begin
                        usp_q <= hwdata;
                    end
                end else begin
                    a_q[wr_addr_q[4:2]] <= hwdata;
                end
            end
            if (wr_addr_q == ADDR_USP) begin
                usp_q <= hwdata;
            end
            if (wr_addr_q == ADDR_SSP) begin
                ssp_q <= hwdata;
            end
        end
    end

    // results and status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_loc_q <= REG_RESET;
            dst_loc_q <= REG_RESET;
            status_q  <= REG_RESET;
        end else if (state_q == ST_IDLE && start) begin
            status_q <= REG_RESET;
        end else if (state_q == ST_SRC) begin
            src_loc_q                   <= loc.value;
            status_q[STAT_LEN_LSB +: 3]  <= len;
            status_q[STAT_SRCX_LSB +: 2] <= ext_words(dec.src_ea);
            status_q[STAT_DSTX_LSB +: 2] <= dec.has_dst ? ext_words(dec.dst_ea) : 2'h0;
            status_q[STAT_IMM_LSB +: 2]  <= dec.imm_words;
            status_q[STAT_SPROG_BIT]     <= loc.is_prog;
            status_q[STAT_SMEM_BIT]      <= loc.is_mem;
            status_q[STAT_HASD_BIT]      <= dec.has_dst;
            status_q[STAT_RSV_BIT]       <= loc.rsv_bad;
            status_q[STAT_UNSUP_BIT]     <= loc.unsup;
            status_q[STAT_SIZE_LSB +: 2] <= dec.size;
        end else if (state_q == ST_DST) begin
            dst_loc_q                <= loc.value;
            status_q[STAT_DMEM_BIT]  <= loc.is_mem;
            status_q[STAT_DPROG_BIT] <= 1'b0;
            status_q[STAT_RSV_BIT]   <= status_q[STAT_RSV_BIT] | loc.rsv_bad;
            status_q[STAT_UNSUP_BIT] <= status_q[STAT_UNSUP_BIT] | loc.unsup;
        end
    end

endmodule

// File: eag_ahb_mst.sv
/* eag_ahb_mst: single-word AHB-Lite master driving the decoder's register port.
   Assumes one slave whose hreadyout is fed back as hready. */
`timescale 1ns/1ns
module eag_ahb_mst (
    input  wire logic        clk,    // bus clock
    input  wire logic        hready, // bus ready
    input  wire logic [31:0] hrdata, // read data
    output logic             hsel,   // select
    output logic [31:0]      haddr,  // address
    output logic [1:0]       htrans, // transfer type
    output logic             hwrite, // write
    output logic [2:0]       hsize,  // always word
    output logic [31:0]      hwdata, // write data
    output logic             stuck   // ready never came
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stuck = 1'b0;
    end
    // waits for the next edge that samples ready high
    task automatic step();
        int i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1)
            stuck <= 1'b1;
    endtask
    // released lines carry the inverse so stale values never look valid
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        step();
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= d;
        step();
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

// File: eag_decoder_chk.sv
/* eag_decoder_chk: port-level properties of the decoder.
   Assumes it is bound to eag_decoder, the only slave on the bus. */
`timescale 1ns/1ns
module eag_decoder_chk
    import eag_pkg::*;
(
    input wire logic        clk,       // clock
    input wire logic        sys_rst,   // reset
    input wire logic        hsel,      // select
    input wire logic [31:0] haddr,     // address
    input wire logic [1:0]  htrans,    // transfer type
    input wire logic        hwrite,    // write
    input wire logic [2:0]  hsize,     // size
    input wire logic [31:0] hwdata,    // write data
    input wire logic        hready,    // ready in
    input wire logic        hreadyout, // ready out
    input wire logic        hresp,     // response
    input wire logic [31:0] hrdata,    // read data
    input wire logic        busy       // decoding
);
    logic rd_take;
    logic st_rd;
    logic wr_ctl_q;
    logic ran_q;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign st_rd = rd_take && haddr[7:2] == 6'h06;
    always_ff @(posedge clk) begin
        if (sys_rst)
            wr_ctl_q <= 1'b0;
        else if (hready)
            wr_ctl_q <= hsel && htrans[1] && hwrite && haddr[7:2] == 6'h00;
    end
    // a decode has started at least once, so status fields are meaningful once busy is low
    always_ff @(posedge clk) begin
        if (sys_rst)
            ran_q <= 1'b0;
        else
            ran_q <= ran_q || busy;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus answer not zero-wait okay");
    property p_rst; $fell(sys_rst) |-> !busy && hrdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_start; wr_ctl_q && hwdata[CTRL_START_BIT] && !busy |=> busy; endproperty
    a_start: assert property (p_start) else $error("start did not raise busy");
    property p_busy; $rose(busy) |-> ##[1:2] !busy; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_hold; !rd_take |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_ctrl; rd_take && haddr[7:2] == 6'h00 |=> !hrdata[CTRL_START_BIT]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("start bit reads back set");
    property p_stbusy; st_rd |=> hrdata[STAT_BUSY_BIT] == $past(busy); endproperty
    a_stbusy: assert property (p_stbusy) else $error("status busy differs from busy");
    property p_unmap; rd_take && haddr[7:2] >= 6'h22 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_len; st_rd && !busy && ran_q |=> hrdata[6:4] inside {[3'h1:3'h5]}; endproperty
    a_len: assert property (p_len) else $error("length outside one to five");
    property p_ext;
        st_rd && !busy && ran_q |=> hrdata[6:4] == 3'h1 + hrdata[9:8] + hrdata[11:10] + hrdata[13:12];
    endproperty
    a_ext: assert property (p_ext) else $error("length not sum of word counts");
    property p_dprog; st_rd && !busy && ran_q |=> !hrdata[STAT_DPROG_BIT]; endproperty
    a_dprog: assert property (p_dprog) else $error("destination tagged program");
    c_start: cover property ($rose(busy));
    c_dst: cover property (busy[*2]);
    c_unmap: cover property (rd_take && haddr[7:2] >= 6'h22);
endmodule
bind eag_decoder eag_decoder_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .busy(busy)
);

// File: eag_decoder_bench.sv
/* eag_decoder_bench: self-checking bench for the effective address decoder.
   Assumes the bus master model and the bound checker. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module eag_decoder_bench
    import eag_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        busy;
    logic        stuck;
    logic        sup;
    logic [31:0] q;
    logic [31:0] st;
    int          n_mismatch;
    int          checks;
    eag_decoder u_dut (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .busy(busy)
    );
    eag_ahb_mst u_mst (
        .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .stuck(stuck)
    );
    initial clk = 1'b0;
    always #5 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        if (stuck === 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_mst.xfer(1'b1, {24'h0, a}, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_mst.xfer(1'b0, {24'h0, a}, 32'h0, q);
    endtask
    // loads one instruction, starts it, waits; leaves status in st and source location in q
    task automatic dec(input logic [15:0] op, input logic [15:0] x0 = 16'h0,
                       input logic [15:0] x1 = 16'h0, input logic [15:0] x2 = 16'h0);
        int i;
        wr(ADDR_OPWORD, {16'h0, op});
        wr(ADDR_EXT0, {16'h0, x0});
        wr(ADDR_EXT0 + 8'h04, {16'h0, x1});
        wr(ADDR_EXT0 + 8'h08, {16'h0, x2});
        wr(ADDR_CTRL, {30'h0, sup, 1'b1});
        for (i = 0; i < 20 && (i == 0 || q[STAT_BUSY_BIT] !== 1'b0); i++)
            rd(ADDR_STATUS);
        if (i == 20) begin
            n_mismatch++;
            print_verdict();
        end
        st = q;
        rd(ADDR_SRC_LOC);
    endtask
    task automatic t_rst();
        rd(ADDR_CTRL);
        `CHK("ctrl", 32'h2, q)
        wr(8'h90, 32'hFFFF_FFFF);
        rd(8'h90);
        `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_direct();
        wr(8'h4C, 32'h1111_2222);
        wr(8'h74, 32'h3333_4444);
        dec(16'h4A03);
        `CHK("dreg", 32'h1111_2222, q)
        `CHK("dreg mem", 1'b0, st[STAT_SMEM_BIT])
        dec(16'h4A0D);
        `CHK("areg", 32'h3333_4444, q)
    endtask
    task automatic t_ind();
        wr(8'h68, 32'h1000);
        dec(16'h4A12);
        `CHK("ind", 32'h1000, q)
        `CHK("ind prog", 1'b0, st[STAT_SPROG_BIT])
        rd(8'h68);
        `CHK("ind keep", 32'h1000, q)
        dec(16'h4ED2);
        `CHK("jump prog", 1'b1, st[STAT_SPROG_BIT])
    endtask
    task automatic t_step();
        logic [31:0] n;
        for (logic [1:0] z = 2'h0; z != 2'h3; z++) begin
            n = {29'h0, z == 2'h2, z == 2'h1, z == 2'h0};
            wr(8'h64, 32'h2000);
            dec({8'h4A, z, 6'h19});
            `CHK("post", 32'h2000, q)
            rd(8'h64);
            `CHK("post reg", 32'h2000 + n, q)
            dec({8'h4A, z, 6'h21});
            `CHK("pre", 32'h2000, q)
        end
        wr(ADDR_SSP, 32'h3000);
        dec(16'h4A1F);
        rd(ADDR_SSP);
        `CHK("sp post", 32'h3002, q)
        dec(16'h4A27);
        `CHK("sp pre", 32'h3000, q)
    endtask
    task automatic t_disp();
        wr(8'h6C, 32'h0001_0000);
        dec(16'h4A2B, 16'hFFFE);
        `CHK("disp", 32'h0000_FFFE, q)
        `CHK("disp ext", 2'h1, st[9:8])
        dec(16'h4EEB, 16'h7FFF);
        `CHK("disp jump", 32'h0001_7FFF, q)
        `CHK("disp prog", 1'b1, st[STAT_SPROG_BIT])
    endtask
    task automatic t_idx();
        logic [15:0] xw [4] = '{16'h6004, 16'h6804, 16'hA0FC, 16'h6704};
        logic [31:0] ex [4] = '{32'h4FF4, 32'h0002_4FF4, 32'h50FC, 32'h4FF4};
        wr(8'h70, 32'h5000);
        wr(8'h58, 32'h0001_FFF0);
        wr(8'h68, 32'h0100);
        for (int i = 0; i < 4; i++) begin
            dec(16'h4A34, xw[i]);
            `CHK("index", ex[i], q)
            `CHK("index rsv", i == 3, st[STAT_RSV_BIT])
        end
    endtask
    task automatic t_sp();
        wr(ADDR_USP, 32'h7000);
        wr(ADDR_SSP, 32'h8000);
        sup = 1'b0;
        dec(16'h4A17);
        `CHK("usp", 32'h7000, q)
        rd(8'h7C);
        `CHK("sp reg", 32'h7000, q)
        sup = 1'b1;
        dec(16'h4A17);
        `CHK("ssp", 32'h8000, q)
    endtask
    task automatic t_order();
        dec(16'h276B, 16'h0010, 16'h0020);
        `CHK("move src", 32'h0001_0010, q)
        `CHK("move len", 3'h3, st[6:4])
        `CHK("dst prog", 1'b0, st[STAT_DPROG_BIT])
        rd(ADDR_DST_LOC);
        `CHK("move dst", 32'h0001_0020, q)
        dec(16'h00AB, 16'hAAAA, 16'hBBBB, 16'h000C);
        `CHK("imm src", 32'h0001_000C, q)
        `CHK("imm len", 3'h4, st[6:4])
        wr(ADDR_OPWORD, 32'h276B);
        wr(ADDR_CTRL, 32'h3);
        wr(8'h40, 32'hDEAD);
        dec(16'h4A00);
        `CHK("busy write", 32'h0, q)
    endtask
    initial begin
        sys_rst = 1'b1;
        sup = 1'b1;
        n_mismatch = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_rst();
        t_direct();
        t_ind();
        t_step();
        t_disp();
        t_idx();
        t_sp();
        t_order();
        print_verdict();
    end
endmodule
